// >>> inc/tfs_defines.svh
// Purpose: constants for the timer flag skip and software reset decoder
// Assumes: 10-bit instruction words
// Notes: opcodes are full 10-bit codes
`ifndef TFS_DEFINES_SVH
`define TFS_DEFINES_SVH
`define TFS_OP_SKIP_T1 10'h280
`define TFS_OP_SKIP_T2 10'h281
`define TFS_OP_SOFTWARE_SYSTEM_RESET_OP 10'h001
`define TFS_T1_EN_BIT 2
`define TFS_T2_EN_BIT 3
`define TFS_RST_FLAGS 2'h0
`endif

// >>> inc/tfs_pkg.sv
// Purpose: types for the timer flag skip and software reset decoder
// Assumes: nothing
// Notes: state is one packed struct
package tfs_pkg;
   // registered state of the decoder
   typedef struct packed {
      logic t1_flag;    // timer 1 request flag
      logic t2_flag;    // timer 2 request flag
      logic skip;       // skip the next instruction
      logic sys_rst;    // software reset request pulse
   } tfs_state_t;
endpackage

// >>> rtl/tfs_decoder.sv
// Purpose: executes the timer-1/timer-2 flag skips and the software system reset
// Assumes: one instruction per valid cycle on core_clk; flags are set by same-clock timers
// Notes: a timer set arriving with a clearing skip wins over the clear
`timescale 1ns/1ps
`include "tfs_defines.svh"
module tfs_decoder (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic instr_valid,          // an instruction executes this cycle
   input wire logic [9:0] instr_word,     // instruction word
   input wire logic [3:0] irq_control_reg_one, // interrupt control register one
   input wire logic timer1_set,           // timer 1 underflow event
   input wire logic timer2_set,           // timer 2 underflow event
   output logic timer1_request_flag,
   output logic timer2_request_flag,
   output logic skip_next,                // skip the following instruction
   output logic carry_write,              // carry is never written here
   output logic software_system_reset_op  // one-cycle reset request
);
   tfs_pkg::tfs_state_t s_q, s_d;
   logic skip_on_timer1_flag;             // timer-1 skip decoded
   logic skip_on_timer2_flag;             // timer-2 skip decoded
   logic software_system_reset_op_hit;                        // reset opcode decoded
   logic timer1_irq_enable_bit;           // timer-1 skip gate, 1 turns the skip into a no-op
   logic timer2_irq_enable_bit;           // timer-2 skip gate, 1 turns the skip into a no-op
   // per-channel views, index 0 is timer 1 and index 1 is timer 2
   logic [1:0] chan_hit;                  // skip opcode decoded for the channel
   logic [1:0] chan_en;                   // gate bit of the channel
   logic [1:0] chan_flag;                 // current request flag of the channel
   logic [1:0] chan_set;                  // timer event for the channel this cycle
   logic [1:0] chan_take;                 // skip taken: gate clear and flag up
   logic [1:0] chan_next;                 // next value of the request flag

   // opcode compare used for each decoded instruction
   function automatic logic is_op(input logic [9:0] w, input logic [9:0] op);
      is_op = (w == op);
   endfunction

   // instruction decode; a word only counts while instr_valid is high
   assign skip_on_timer1_flag = instr_valid && is_op(instr_word, `TFS_OP_SKIP_T1);
   assign skip_on_timer2_flag = instr_valid && is_op(instr_word, `TFS_OP_SKIP_T2);
   assign software_system_reset_op_hit = instr_valid && is_op(instr_word, `TFS_OP_SOFTWARE_SYSTEM_RESET_OP);
   assign timer1_irq_enable_bit = irq_control_reg_one[`TFS_T1_EN_BIT];
   assign timer2_irq_enable_bit = irq_control_reg_one[`TFS_T2_EN_BIT];

   // gather both timer channels so one loop body serves them
   assign chan_hit = {skip_on_timer2_flag, skip_on_timer1_flag};
   assign chan_en = {timer2_irq_enable_bit, timer1_irq_enable_bit};
   assign chan_flag = {s_q.t2_flag, s_q.t1_flag};
   assign chan_set = {timer2_set, timer1_set};

   // the two skips differ only in opcode, gate bit and flag
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_chan
         // a skip is taken only with the gate open and the flag up
         assign chan_take[g] = chan_hit[g] && !chan_en[g] && chan_flag[g];
         // a timer event in the same cycle as a clearing skip wins, so no
         // underflow is ever dropped; the skip itself still happens
         assign chan_next[g] = chan_set[g] || (chan_flag[g] && !chan_take[g]);
      end
   endgenerate

   // next state: flags from the channel loop, skip and reset as one-cycle pulses
   always_comb begin
      s_d = s_q;
      // both pulses fall back to zero unless an instruction raises them
      s_d.skip = 1'h0;
      s_d.sys_rst = 1'h0;
      s_d.t1_flag = chan_next[0];
      s_d.t2_flag = chan_next[1];
      // only one opcode can match per cycle, so at most one channel takes
      if (|chan_take) begin
         s_d.skip = 1'h1;
      end else begin
         // gate set or flag clear: the next instruction runs as normal
         s_d.skip = 1'h0;
      end
      // the reset op only requests; the system reset comes back through nrst
      if (software_system_reset_op_hit) begin
         s_d.sys_rst = 1'h1;
      end
   end

   // state register; the software reset itself does not clear the flags here,
   // the system reset it requests does that through nrst
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         // every output reads zero from the first edge of reset onwards
         {s_q.t1_flag, s_q.t2_flag} <= `TFS_RST_FLAGS;
         s_q.skip <= 1'h0;
         s_q.sys_rst <= 1'h0;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state flops, so each one is glitch free
   assign timer1_request_flag = s_q.t1_flag;
   assign timer2_request_flag = s_q.t2_flag;
   assign skip_next = s_q.skip;
   assign software_system_reset_op = s_q.sys_rst;
   // the skips never touch carry, so its write strobe is tied off
   assign carry_write = 1'h0;

   // checks below are all held off while the synchronous reset is low

   property p_t1_skip;
      @(posedge core_clk) disable iff (!nrst)
      skip_on_timer1_flag && !timer1_irq_enable_bit && timer1_request_flag && !timer1_set
      |=> skip_next && !timer1_request_flag;
   endproperty
   a_t1_skip: assert property (p_t1_skip) else $error("t1 skip failed");

   property p_t1_nop;
      @(posedge core_clk) disable iff (!nrst)
      skip_on_timer1_flag && timer1_irq_enable_bit && timer1_request_flag && !skip_on_timer2_flag
      |=> !skip_next && timer1_request_flag;
   endproperty
   a_t1_nop: assert property (p_t1_nop) else $error("t1 nop failed");

   property p_t1_zero;
      @(posedge core_clk) disable iff (!nrst)
      skip_on_timer1_flag && !timer1_request_flag |=> !skip_next;
   endproperty
   a_t1_zero: assert property (p_t1_zero) else $error("t1 zero skipped");

   property p_t2_skip;
      @(posedge core_clk) disable iff (!nrst)
      skip_on_timer2_flag && !timer2_irq_enable_bit && timer2_request_flag && !timer2_set
      |=> skip_next && !timer2_request_flag;
   endproperty
   a_t2_skip: assert property (p_t2_skip) else $error("t2 skip failed");

   property p_t2_nop;
      @(posedge core_clk) disable iff (!nrst)
      skip_on_timer2_flag && timer2_irq_enable_bit && timer2_request_flag
      |=> !skip_next && timer2_request_flag;
   endproperty
   a_t2_nop: assert property (p_t2_nop) else $error("t2 nop failed");

   property p_t2_zero;
      @(posedge core_clk) disable iff (!nrst)
      skip_on_timer2_flag && !timer2_request_flag |=> !skip_next;
   endproperty
   a_t2_zero: assert property (p_t2_zero) else $error("t2 zero skipped");

   property p_software_system_reset_op;
      @(posedge core_clk) disable iff (!nrst)
      software_system_reset_op_hit |=> software_system_reset_op;
   endproperty
   a_software_system_reset_op: assert property (p_software_system_reset_op) else $error("reset op missed");

   property p_software_system_reset_op_only;
      @(posedge core_clk) disable iff (!nrst)
      software_system_reset_op |-> $past(software_system_reset_op_hit);
   endproperty
   a_software_system_reset_op_only: assert property (p_software_system_reset_op_only) else $error("spurious reset");

   property p_set_wins;
      @(posedge core_clk) disable iff (!nrst)
      timer1_set |=> timer1_request_flag;
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("t1 set lost");

   property p_set2_wins;
      @(posedge core_clk) disable iff (!nrst)
      timer2_set |=> timer2_request_flag;
   endproperty
   a_set2_wins: assert property (p_set2_wins) else $error("t2 set lost");

   // a skip that meets its own timer event still skips, the flag stays up
   property p_t1_set_skip;
      @(posedge core_clk) disable iff (!nrst)
      skip_on_timer1_flag && !timer1_irq_enable_bit && timer1_request_flag && timer1_set
      |=> skip_next && timer1_request_flag;
   endproperty
   a_t1_set_skip: assert property (p_t1_set_skip) else $error("t1 set skip lost");

   // same race on the second channel
   property p_t2_set_skip;
      @(posedge core_clk) disable iff (!nrst)
      skip_on_timer2_flag && !timer2_irq_enable_bit && timer2_request_flag && timer2_set
      |=> skip_next && timer2_request_flag;
   endproperty
   a_t2_set_skip: assert property (p_t2_set_skip) else $error("t2 set skip lost");

   // with no skip opcode and no timer event the flag holds its value
   property p_t1_hold;
      @(posedge core_clk) disable iff (!nrst)
      !skip_on_timer1_flag && !timer1_set |=> $stable(timer1_request_flag);
   endproperty
   a_t1_hold: assert property (p_t1_hold) else $error("t1 flag moved");

   property p_t2_hold;
      @(posedge core_clk) disable iff (!nrst)
      !skip_on_timer2_flag && !timer2_set |=> $stable(timer2_request_flag);
   endproperty
   a_t2_hold: assert property (p_t2_hold) else $error("t2 flag moved");

   // no taken skip on either channel means no skip pulse afterwards
   property p_skip_cause;
      @(posedge core_clk) disable iff (!nrst)
      !(skip_on_timer1_flag && !timer1_irq_enable_bit && timer1_request_flag)
      && !(skip_on_timer2_flag && !timer2_irq_enable_bit && timer2_request_flag)
      |=> !skip_next;
   endproperty
   a_skip_cause: assert property (p_skip_cause) else $error("skip without cause");
endmodule

// >>> testbench/tb_tfs_decoder.sv
// Purpose: self-checking bench for the timer flag skip and software reset decoder
// Assumes: one instruction every other cycle, outputs registered one edge after the op
// Notes: flags are raised through the timer pulses; some skips are also tried with the flag clear
`timescale 1ns/1ps
module tb_tfs_decoder;
   logic core_clk, nrst, instr_valid, timer1_set, timer2_set;
   logic [9:0] instr_word;
   logic [3:0] irq_control_reg_one; // bit2 gates timer 1, bit3 gates timer 2
   logic t1f, t2f, skip, cwr, rst_op;
   int error_cnt = 0;
   int total_checks = 0;
   tfs_decoder tfs_decoder_inst (.core_clk(core_clk), .nrst(nrst), .instr_valid(instr_valid),
      .instr_word(instr_word), .irq_control_reg_one(irq_control_reg_one),
      .timer1_set(timer1_set), .timer2_set(timer2_set), .timer1_request_flag(t1f),
      .timer2_request_flag(t2f), .skip_next(skip), .carry_write(cwr),
      .software_system_reset_op(rst_op));
   // free-running core clock, 8 ns period
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   task automatic conclude();
      if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // compare {flag1, flag2, skip, reset pulse, carry write} in one go
   task automatic chk(input logic [4:0] e);
      total_checks++;
      if ({t1f, t2f, skip, rst_op, cwr} !== e) begin
         error_cnt++;
         $display("mismatch at %0t: got %b expected %b", $time, {t1f, t2f, skip, rst_op, cwr}, e);
      end
   endtask
   // pulse the timer events for one cycle so the flags are raised
   task automatic setf(input logic a, input logic b);
      @(posedge core_clk);
      timer1_set <= a;
      timer2_set <= b;
      @(posedge core_clk);
      timer1_set <= 1'h0;
      timer2_set <= 1'h0;
   endtask
   // one cycle of valid, word, gate and timer events together, then check
   task automatic step(input logic v, input logic [9:0] w, input logic [3:0] c,
      input logic [1:0] ts, input logic [4:0] e);
      @(posedge core_clk);
      instr_valid <= v;
      instr_word <= w;
      irq_control_reg_one <= c;
      timer1_set <= ts[0];
      timer2_set <= ts[1];
      @(posedge core_clk);
      instr_valid <= 1'h0;
      timer1_set <= 1'h0;
      timer2_set <= 1'h0;
      #1 chk(e);
   endtask
   // one instruction cycle, then look at the registered answer
   task automatic run(input logic [9:0] w, input logic [3:0] c, input logic [4:0] e);
      step(1'h1, w, c, 2'h0, e);
   endtask
   // watchdog: the whole sequence needs well under 100 cycles
   initial begin
      #4000;
      error_cnt++;
      conclude();
   end
   // main sequence
   initial begin
      nrst <= 1'h0;
      instr_valid <= 1'h0;
      instr_word <= 10'h000;
      irq_control_reg_one <= 4'h0;
      timer1_set <= 1'h0;
      timer2_set <= 1'h0;
      repeat (10) @(posedge core_clk);
      nrst <= 1'h1;
      #1 chk(5'h00);
      setf(1'h1, 1'h1);
      run(10'h280, 4'h0, 5'h0c);
      run(10'h280, 4'h0, 5'h08);
      run(10'h281, 4'h0, 5'h04);
      setf(1'h1, 1'h1);
      run(10'h280, 4'h4, 5'h18);
      run(10'h281, 4'h8, 5'h18);
      run(10'h281, 4'h4, 5'h14);
      run(10'h001, 4'h0, 5'h12);
      run(10'h000, 4'h0, 5'h10);
      step(1'h0, 10'h280, 4'h0, 2'h0, 5'h10);
      run(10'h281, 4'h0, 5'h10);
      step(1'h1, 10'h280, 4'h0, 2'h1, 5'h14);
      step(1'h1, 10'h281, 4'h0, 2'h2, 5'h18);
      step(1'h1, 10'h281, 4'h0, 2'h2, 5'h1c);
      run(10'h001, 4'h0, 5'h1a);
      // the system answers the reset request by pulling nrst low
      @(posedge core_clk);
      nrst <= 1'h0;
      repeat (2) @(posedge core_clk);
      nrst <= 1'h1;
      #1 chk(5'h00);
      setf(1'h1, 1'h0);
      run(10'h280, 4'h0, 5'h04);
      conclude();
   end
endmodule
